//--- lru_writeback_word_cache_cfg.svh
// constants for the lru write-back word cache
`ifndef LRU_WRITEBACK_WORD_CACHE_CFG_SVH
`define LRU_WRITEBACK_WORD_CACHE_CFG_SVH
`define CACHE_WORD_W 36
`define CACHE_ADDR_W 18
`define CACHE_WORDS 2048
`define CACHE_LINES 512
`define CACHE_LINE_W 9
`define CACHE_WAYS 4
`define CACHE_SET_W 7
`define CACHE_PAGE_BITS 9
`define CACHE_AGE_OLDEST 2'h3
`define CACHE_LAST_WORD 2'h3
`define CACHE_LAST_LINE 9'h1FF
`endif

//--- lru_writeback_word_cache_pkg.sv
// types for the lru write-back word cache
package lru_writeback_word_cache_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WB = 3'h1,
    ST_ALLOC = 3'h2,
    ST_FILL = 3'h3,
    ST_FLUSH = 3'h4
  } cache_state_e;
  typedef logic [1:0] age_t;
endpackage

//--- lru_writeback_word_cache.sv
// four-way lru write-back cache of four-word groups
`timescale 1ns/100ps
`default_nettype none
`include "lru_writeback_word_cache_cfg.svh"
module lru_writeback_word_cache #(
  parameter int WORD_W = `CACHE_WORD_W,
  parameter int ADDR_W = `CACHE_ADDR_W
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [WORD_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic [WORD_W-1:0] resp_rdata_out,
  output logic mem_req_valid_out,
  output logic mem_req_write_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [WORD_W-1:0] mem_wdata_out,
  input wire logic mem_ready_in,
  input wire logic mem_rvalid_in,
  input wire logic [WORD_W-1:0] mem_rdata_in,
  input wire logic flush_in,
  output logic flush_busy_out,
  output logic flush_done_out
);
  localparam int TAG_W = ADDR_W - `CACHE_PAGE_BITS;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [`CACHE_LINE_W-1:0] line_of(input logic [`CACHE_SET_W-1:0] set,
                                                     input logic [1:0] way);
    line_of = {set, way};
  endfunction

  function automatic logic [`CACHE_LINE_W+1:0] word_of(input logic [`CACHE_LINE_W-1:0] line,
                                                     input logic [1:0] word);
    word_of = {line, word};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage arrays: 512 groups x 4 words
  logic [WORD_W-1:0] data_mem [0:`CACHE_WORDS-1];
  logic [TAG_W-1:0] tag_mem [0:`CACHE_LINES-1];
  logic [3:0] present_reg [0:`CACHE_LINES-1];
  logic [`CACHE_LINES-1:0] dirty_reg;
  logic [`CACHE_LINES-1:0] line_valid_reg;
  lru_writeback_word_cache_pkg::age_t age_reg [0:`CACHE_LINES-1];

  lru_writeback_word_cache_pkg::cache_state_e state_reg;
  logic [`CACHE_LINE_W-1:0] line_reg;
  logic [`CACHE_LINE_W-1:0] scan_reg;
  logic [1:0] word_reg;
  logic pend_reg;
  logic wb_for_flush_reg;
  logic flush_pend_reg;
  logic mem_req_valid_reg;
  logic mem_req_write_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [WORD_W-1:0] mem_wdata_reg;
  logic resp_valid_reg;
  logic [WORD_W-1:0] resp_rdata_reg;
  logic flush_done_reg;

  ////////////////////////////////////////////////////////////////////////////
  logic [`CACHE_SET_W-1:0] req_set;
  logic [1:0] req_word;
  logic [TAG_W-1:0] req_tag;
  logic tag_hit;
  logic [1:0] hit_way;
  logic [1:0] victim_way;
  logic [`CACHE_LINE_W-1:0] hit_line;
  logic [`CACHE_LINE_W-1:0] victim_line;
  logic wr_hit;
  logic fill_word;
  logic wb_done;
  logic alloc;
  logic step;

  assign req_set = req_addr_in[`CACHE_PAGE_BITS-1:2];
  assign req_word = req_addr_in[1:0];
  assign req_tag = req_addr_in[ADDR_W-1:`CACHE_PAGE_BITS];

  always_comb
  begin
    tag_hit = 1'b0;
    hit_way = 2'h0;
    victim_way = 2'h0;
    for (int w = `CACHE_WAYS - 1; w >= 0; w--)
    begin
      if (line_valid_reg[line_of(req_set, w[1:0])] && tag_mem[line_of(req_set, w[1:0])] == req_tag)
      begin
        tag_hit = 1'b1;
        hit_way = w[1:0];
      end
    end
    // an empty way beats the oldest one
    for (int w = `CACHE_WAYS - 1; w >= 0; w--)
    begin
      if (age_reg[line_of(req_set, w[1:0])] == `CACHE_AGE_OLDEST)
        victim_way = w[1:0];
    end
    for (int w = `CACHE_WAYS - 1; w >= 0; w--)
    begin
      if (!line_valid_reg[line_of(req_set, w[1:0])])
        victim_way = w[1:0];
    end
  end

  assign hit_line = line_of(req_set, hit_way);
  assign victim_line = line_of(req_set, victim_way);

  // a word written into an otherwise empty group still completes here
  assign req_ready_out = ce_in && state_reg == lru_writeback_word_cache_pkg::ST_IDLE && !flush_pend_reg &&
                         req_valid_in && tag_hit && (req_write_in || present_reg[hit_line][req_word]);
  assign wr_hit = req_ready_out && req_write_in;
  assign fill_word = ce_in && state_reg == lru_writeback_word_cache_pkg::ST_FILL && pend_reg && mem_rvalid_in;
  assign alloc = ce_in && state_reg == lru_writeback_word_cache_pkg::ST_ALLOC;
  // step: current word of a write-back or fill is finished
  assign step = (state_reg == lru_writeback_word_cache_pkg::ST_WB &&
                 (mem_req_valid_reg ? mem_ready_in : !present_reg[line_reg][word_reg])) ||
                (state_reg == lru_writeback_word_cache_pkg::ST_FILL &&
                 (pend_reg ? mem_rvalid_in : (!mem_req_valid_reg && present_reg[line_reg][word_reg])));
  assign wb_done = ce_in && state_reg == lru_writeback_word_cache_pkg::ST_WB && step &&
                   word_reg == `CACHE_LAST_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= lru_writeback_word_cache_pkg::ST_IDLE;
      line_reg <= '0;
      scan_reg <= '0;
      word_reg <= 2'h0;
      wb_for_flush_reg <= 1'b0;
      flush_done_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      flush_done_reg <= 1'b0;
      word_reg <= step ? word_reg + 2'h1 : word_reg;
      unique case (state_reg)
        lru_writeback_word_cache_pkg::ST_IDLE:
        begin
          word_reg <= 2'h0;
          if (flush_pend_reg)
          begin
            scan_reg <= '0;
            state_reg <= lru_writeback_word_cache_pkg::ST_FLUSH;
          end
          else if (req_valid_in && !tag_hit)
          begin
            line_reg <= victim_line;
            wb_for_flush_reg <= 1'b0;
            if (line_valid_reg[victim_line] && dirty_reg[victim_line])
              state_reg <= lru_writeback_word_cache_pkg::ST_WB;
            else
              state_reg <= lru_writeback_word_cache_pkg::ST_ALLOC;
          end
          else if (req_valid_in && !req_write_in && !present_reg[hit_line][req_word])
          begin
            line_reg <= hit_line;
            state_reg <= lru_writeback_word_cache_pkg::ST_FILL;
          end
        end
        lru_writeback_word_cache_pkg::ST_WB:
          if (wb_done)
            state_reg <= wb_for_flush_reg ? lru_writeback_word_cache_pkg::ST_FLUSH
                                          : lru_writeback_word_cache_pkg::ST_ALLOC;
        lru_writeback_word_cache_pkg::ST_ALLOC:
          state_reg <= lru_writeback_word_cache_pkg::ST_IDLE;
        lru_writeback_word_cache_pkg::ST_FILL:
          if (step && word_reg == `CACHE_LAST_WORD)
            state_reg <= lru_writeback_word_cache_pkg::ST_IDLE;
        lru_writeback_word_cache_pkg::ST_FLUSH:
        begin
          // the same line is rechecked after its write-back, now clean
          word_reg <= 2'h0;
          if (line_valid_reg[scan_reg] && dirty_reg[scan_reg])
          begin
            line_reg <= scan_reg;
            wb_for_flush_reg <= 1'b1;
            state_reg <= lru_writeback_word_cache_pkg::ST_WB;
          end
          else if (scan_reg == `CACHE_LAST_LINE)
          begin
            flush_done_reg <= 1'b1;
            state_reg <= lru_writeback_word_cache_pkg::ST_IDLE;
          end
          else
            scan_reg <= scan_reg + 9'h001;
        end
        default:
          state_reg <= lru_writeback_word_cache_pkg::ST_IDLE;
      endcase
    end
  end

  // storage port: one word per request, reads have one outstanding
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mem_req_valid_reg <= 1'b0;
      mem_req_write_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= '0;
      pend_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (mem_req_valid_reg && mem_ready_in)
        mem_req_valid_reg <= 1'b0;
      if (fill_word)
        pend_reg <= 1'b0;
      if (!mem_req_valid_reg && !pend_reg && present_reg[line_reg][word_reg] == 
          (state_reg == lru_writeback_word_cache_pkg::ST_WB) &&
          (state_reg == lru_writeback_word_cache_pkg::ST_WB || state_reg == lru_writeback_word_cache_pkg::ST_FILL))
      begin
        mem_req_valid_reg <= 1'b1;
        mem_req_write_reg <= state_reg == lru_writeback_word_cache_pkg::ST_WB;
        mem_addr_reg <= {tag_mem[line_reg], line_reg[`CACHE_LINE_W-1:2], word_reg};
        mem_wdata_reg <= data_mem[word_of(line_reg, word_reg)];
        pend_reg <= state_reg == lru_writeback_word_cache_pkg::ST_FILL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // group metadata
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dirty_reg <= '0;
      line_valid_reg <= '0;
      for (int i = 0; i < `CACHE_LINES; i++)
        present_reg[i] <= 4'h0;
    end
    else if (ce_in)
    begin
      if (wr_hit)
      begin
        present_reg[hit_line][req_word] <= 1'b1;
        dirty_reg[hit_line] <= 1'b1;
      end
      if (fill_word)
        present_reg[line_reg][word_reg] <= 1'b1;
      if (wb_done)
        dirty_reg[line_reg] <= 1'b0;
      if (alloc)
      begin
        present_reg[line_reg] <= 4'h0;
        dirty_reg[line_reg] <= 1'b0;
        line_valid_reg[line_reg] <= 1'b1;
      end
    end
  end

  // recency: touched way becomes 0, younger ways age by one
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < `CACHE_LINES; i++)
        age_reg[i] <= i[1:0];
    end
    else if (req_ready_out)
    begin
      for (int w = 0; w < `CACHE_WAYS; w++)
      begin
        if (w[1:0] == hit_way)
          age_reg[line_of(req_set, w[1:0])] <= 2'h0;
        else if (age_reg[line_of(req_set, w[1:0])] < age_reg[hit_line])
          age_reg[line_of(req_set, w[1:0])] <= age_reg[line_of(req_set, w[1:0])] + 2'h1;
      end
    end
  end

  // data arrays carry no reset; presence bits guard them
  always_ff @(posedge clk_in)
  begin
    if (ce_in)
    begin
      if (wr_hit)
        data_mem[word_of(hit_line, req_word)] <= req_wdata_in;
      if (fill_word)
        data_mem[word_of(line_reg, word_reg)] <= mem_rdata_in;
      if (alloc)
        tag_mem[line_reg] <= req_tag;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      resp_valid_reg <= 1'b0;
      resp_rdata_reg <= '0;
    end
    else if (ce_in)
    begin
      resp_valid_reg <= req_ready_out && !req_write_in;
      if (req_ready_out && !req_write_in)
        resp_rdata_reg <= data_mem[word_of(hit_line, req_word)];
    end
  end

  // a command arriving as the previous one finishes is kept
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      flush_pend_reg <= 1'b0;
    else if (ce_in)
      flush_pend_reg <= flush_in || (flush_pend_reg && !(state_reg == lru_writeback_word_cache_pkg::ST_FLUSH &&
                        !(line_valid_reg[scan_reg] && dirty_reg[scan_reg]) && scan_reg == `CACHE_LAST_LINE));
  end

  assign resp_valid_out = resp_valid_reg;
  assign resp_rdata_out = resp_rdata_reg;
  assign mem_req_valid_out = mem_req_valid_reg;
  assign mem_req_write_out = mem_req_write_reg;
  assign mem_addr_out = mem_addr_reg;
  assign mem_wdata_out = mem_wdata_reg;
  assign flush_busy_out = flush_pend_reg;
  assign flush_done_out = flush_done_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_read_hit_resp: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    req_ready_out && !req_write_in |=> resp_valid_out)
    else $error("read hit gave no response");
  a_hit_no_storage: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    req_ready_out |-> !mem_req_valid_out)
    else $error("hit overlapped a storage request");
  a_write_no_storage: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_hit |=> !mem_req_valid_out && state_reg == lru_writeback_word_cache_pkg::ST_IDLE)
    else $error("program write reached storage");
  a_fill_aligned_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state_reg == lru_writeback_word_cache_pkg::ST_FILL && mem_req_valid_out |->
      !mem_req_write_out && mem_addr_out[ADDR_W-1:2] == req_addr_in[ADDR_W-1:2])
    else $error("fill request not an aligned read");
  a_victim_oldest: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state_reg == lru_writeback_word_cache_pkg::ST_ALLOC && line_valid_reg[line_reg] |->
      age_reg[line_reg] == `CACHE_AGE_OLDEST)
    else $error("victim not least recently used");
  a_clean_discard: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state_reg == lru_writeback_word_cache_pkg::ST_ALLOC |-> !(line_valid_reg[line_reg] && dirty_reg[line_reg]))
    else $error("modified victim reused without write-back");
  a_write_sets_word: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_hit |=> present_reg[$past(hit_line)][$past(req_word)] && dirty_reg[$past(hit_line)])
    else $error("written word not present and modified");
  a_flush_all_clean: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    flush_done_out |-> (dirty_reg & line_valid_reg) == '0)
    else $error("update finished with modified groups");
  a_flush_keeps_valid: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wb_done && wb_for_flush_reg |=> line_valid_reg[$past(line_reg)] && !dirty_reg[$past(line_reg)])
    else $error("updated group lost or still modified");
endmodule
`default_nettype wire

//--- lru_writeback_word_cache_storage.sv
// storage model answering the cache's word requests
`timescale 1ns/100ps
`default_nettype none
module storage_model (
  input wire logic clk_in,
  input wire logic mem_req_valid_in,
  input wire logic mem_req_write_in,
  input wire logic [17:0] mem_addr_in,
  input wire logic [35:0] mem_wdata_in,
  input var int slow_in,
  output logic mem_ready_out,
  output logic mem_rvalid_out,
  output logic [35:0] mem_rdata_out,
  output int rd_cnt_out,
  output int wr_cnt_out
);
  logic [35:0] store [logic [17:0]];
  logic [17:0] pend_addr;
  logic pend;
  int waited;
  // untouched words read back as a pattern made from their address
  function automatic logic [35:0] peek(input logic [17:0] a);
    peek = store.exists(a) ? store[a] : {a, ~a};
  endfunction
  initial
  begin
    mem_ready_out = 1'b0;
    mem_rvalid_out = 1'b0;
    mem_rdata_out = 36'h000000000;
    pend = 1'b0;
    waited = 0;
    rd_cnt_out = 0;
    wr_cnt_out = 0;
  end
  // idle data lines flip every cycle so stale data never looks valid
  always @(negedge clk_in)
  begin
    mem_ready_out = 1'b0;
    mem_rvalid_out = 1'b0;
    mem_rdata_out = ~mem_rdata_out;
    if (pend)
    begin
      mem_rvalid_out = 1'b1;
      mem_rdata_out = peek(pend_addr);
      pend = 1'b0;
    end
    else if (mem_req_valid_in === 1'b1)
    begin
      if (waited >= slow_in)
      begin
        mem_ready_out = 1'b1;
        waited = 0;
      end
      else
        waited++;
    end
  end
  always @(posedge clk_in)
  begin
    if (mem_req_valid_in === 1'b1 && mem_ready_out)
    begin
      if (mem_req_write_in)
      begin
        store[mem_addr_in] = mem_wdata_in;
        wr_cnt_out++;
      end
      else
      begin
        pend_addr = mem_addr_in;
        pend = 1'b1;
        rd_cnt_out++;
      end
    end
  end
endmodule
`default_nettype wire

//--- lru_writeback_word_cache_bench.sv
// self-checking bench for the lru write-back word cache
`timescale 1ns/100ps
`default_nettype none
module lru_writeback_word_cache_bench;
  logic clk_in = 1'b0;
  logic reset_n_in, ce_in, req_valid_in, req_write_in, req_ready_out, resp_valid_out;
  logic [17:0] req_addr_in, mem_addr_out;
  logic [35:0] req_wdata_in, resp_rdata_out, mem_wdata_out, mem_rdata_in;
  logic mem_req_valid_out, mem_req_write_out, mem_ready_in, mem_rvalid_in;
  logic flush_in, flush_busy_out, flush_done_out;
  int slow, rd_cnt, wr_cnt, error_cnt, n_compared, cycles, r0, w0;
  always #2.5 clk_in = ~clk_in;
  lru_writeback_word_cache dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
    .resp_rdata_out(resp_rdata_out), .mem_req_valid_out(mem_req_valid_out),
    .mem_req_write_out(mem_req_write_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_ready_in(mem_ready_in), .mem_rvalid_in(mem_rvalid_in), .mem_rdata_in(mem_rdata_in),
    .flush_in(flush_in), .flush_busy_out(flush_busy_out), .flush_done_out(flush_done_out));
  storage_model mem (.clk_in(clk_in), .mem_req_valid_in(mem_req_valid_out),
    .mem_req_write_in(mem_req_write_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .slow_in(slow), .mem_ready_out(mem_ready_in), .mem_rvalid_out(mem_rvalid_in),
    .mem_rdata_out(mem_rdata_in), .rd_cnt_out(rd_cnt), .wr_cnt_out(wr_cnt));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] init_word(input logic [17:0] a);
    init_word = {a, ~a};
  endfunction
  function automatic logic [17:0] page_addr(input int t, input logic [6:0] pos, input int w);
    page_addr = {9'(t), pos, 2'(w)};
  endfunction
  task automatic fail(input string msg);
    $display("mismatch at %0t: %s", $time, msg);
    error_cnt++;
  endtask
  task automatic check_word(input logic [35:0] got, input logic [35:0] exp, input string msg);
    n_compared++;
    if (got !== exp) fail(msg);
  endtask
  task automatic check_int(input int got, input int exp, input string msg);
    n_compared++;
    if (got != exp) fail(msg);
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) fail(msg);
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // request held from a falling edge until the edge that takes it
  task automatic access(input logic wr, input logic [17:0] a, input logic [35:0] d, output logic [35:0] q);
    int n;
    n = 0;
    q = 36'h000000000;
    @(negedge clk_in);
    req_valid_in = 1'b1;
    req_write_in = wr;
    req_addr_in = a;
    req_wdata_in = d;
    #1;
    while (req_ready_out !== 1'b1 && n < 4000)
    begin
      @(negedge clk_in);
      #1;
      n++;
    end
    if (n >= 4000) fail("request never taken");
    @(negedge clk_in);
    req_valid_in = 1'b0;
    if (!wr)
    begin
      check_bit(resp_valid_out, 1'b1, "no read response");
      q = resp_rdata_out;
    end
  endtask
  task automatic read_check(input logic [17:0] a, input logic [35:0] exp);
    logic [35:0] q;
    access(1'b0, a, 36'h000000000, q);
    check_word(q, exp, "read data");
  endtask
  task automatic write_word(input logic [17:0] a, input logic [35:0] d);
    logic [35:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic do_flush;
    int n;
    n = 0;
    @(negedge clk_in);
    flush_in = 1'b1;
    @(negedge clk_in);
    flush_in = 1'b0;
    check_bit(flush_busy_out, 1'b1, "not busy after command");
    while (flush_done_out !== 1'b1 && n < 5000)
    begin
      @(negedge clk_in);
      n++;
    end
    check_bit(flush_done_out, 1'b1, "update never finished");
    check_bit(flush_busy_out, 1'b0, "busy with done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_fill;
    r0 = rd_cnt;
    read_check(18'h00205, init_word(18'h00205));
    check_int(rd_cnt - r0, 4, "fill count");
    for (int i = 0; i < 4; i++)
      read_check(18'h00204 + 18'(i), init_word(18'h00204 + 18'(i)));
    check_int(rd_cnt - r0, 4, "hit went to storage");
    $display("test fill done");
  endtask
  task automatic test_write;
    r0 = rd_cnt;
    w0 = wr_cnt;
    write_word(18'h0020A, 36'h123456789);
    check_int(rd_cnt + wr_cnt - r0 - w0, 0, "write touched storage");
    read_check(18'h0020A, 36'h123456789);
    check_int(rd_cnt - r0, 0, "lone written word not held");
    read_check(18'h00209, init_word(18'h00209));
    check_int(rd_cnt - r0, 3, "fetched a held word");
    $display("test write done");
  endtask
  // eight pages share one position, so once four are held the oldest goes each time
  task automatic test_lru;
    slow = 3;
    r0 = rd_cnt;
    w0 = wr_cnt;
    for (int t = 1; t < 5; t++)
      read_check(page_addr(t, 7'h05, 0), init_word(page_addr(t, 7'h05, 0)));
    write_word(page_addr(1, 7'h05, 1), 36'h0CAFE0001);
    for (int t = 5; t < 8; t++)
      read_check(page_addr(t, 7'h05, 0), init_word(page_addr(t, 7'h05, 0)));
    check_int(wr_cnt - w0, 0, "clean victim written");
    read_check(page_addr(8, 7'h05, 0), init_word(page_addr(8, 7'h05, 0)));
    check_int(wr_cnt - w0, 4, "dirty victim count");
    check_word(mem.peek(page_addr(1, 7'h05, 1)), 36'h0CAFE0001, "written back data");
    r0 = rd_cnt;
    for (int t = 5; t < 9; t++)
      read_check(page_addr(t, 7'h05, 0), init_word(page_addr(t, 7'h05, 0)));
    check_int(rd_cnt - r0, 0, "wrong victim chosen");
    read_check(page_addr(1, 7'h05, 1), 36'h0CAFE0001);
    $display("test lru done");
  endtask
  task automatic test_flush;
    slow = 1;
    write_word(18'h00627, 36'hFEDCBA987);
    w0 = wr_cnt;
    do_flush();
    check_int(wr_cnt - w0, 5, "update write count");
    check_word(mem.peek(18'h0020A), 36'h123456789, "updated word");
    check_word(mem.peek(18'h00627), 36'hFEDCBA987, "updated word");
    r0 = rd_cnt;
    read_check(18'h00627, 36'hFEDCBA987);
    check_int(rd_cnt - r0, 0, "group lost by update");
    w0 = wr_cnt;
    do_flush();
    check_int(wr_cnt - w0, 0, "group still modified");
    $display("test flush done");
  endtask
  // ce_in low must freeze a held read hit until it rises again
  task automatic test_hold;
    r0 = rd_cnt;
    @(negedge clk_in);
    ce_in = 1'b0;
    req_valid_in = 1'b1;
    req_write_in = 1'b0;
    req_addr_in = 18'h00627;
    repeat (4)
    begin
      #1;
      check_bit(req_ready_out, 1'b0, "taken while frozen");
      check_bit(resp_valid_out, 1'b0, "answered while frozen");
      @(negedge clk_in);
    end
    ce_in = 1'b1;
    #1;
    check_bit(req_ready_out, 1'b1, "hit not taken after freeze");
    @(negedge clk_in);
    req_valid_in = 1'b0;
    check_bit(resp_valid_out, 1'b1, "no response after freeze");
    check_word(resp_rdata_out, 36'hFEDCBA987, "data after freeze");
    check_int(rd_cnt - r0, 0, "frozen hit went to storage");
    $display("test hold done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // ceiling well above the under two thousand cycles the tests need
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      fail("timeout");
      test_done();
    end
  end
  initial
  begin
    {reset_n_in, req_valid_in, req_write_in, flush_in} = 4'h0;
    ce_in = 1'b1;
    req_addr_in = 18'h00000;
    req_wdata_in = 36'h000000000;
    {slow, error_cnt, n_compared, cycles} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    test_fill();
    test_write();
    test_lru();
    test_flush();
    test_hold();
    test_done();
  end
endmodule
`default_nettype wire
